/* File: logic/pwr_pkg.sv */
package pwr_pkg;
    // ------------------------------------------------
    // Address map
    // ------------------------------------------------
    localparam logic [7:0] ADDR_ID   = 8'h00;
    localparam logic [7:0] ADDR_MID  = 8'h04;
    localparam logic [7:0] ADDR_BIAS = 8'h05;
    localparam logic [7:0] ADDR_PWR  = 8'h0b;
    localparam logic [7:0] ADDR_CLK  = 8'h0e;
    localparam logic [7:0] ADDR_FLL  = 8'h10;
    localparam logic [7:0] ADDR_DRC  = 8'h20;
    localparam logic [7:0] ADDR_WSEQ = 8'h26;
    localparam logic [7:0] ADDR_EQ   = 8'h2a;
    localparam int NREG = 8;
    typedef enum logic [2:0] {
        IX_MID, IX_BIAS, IX_PWR, IX_CLK,
        IX_FLL, IX_DRC, IX_WSEQ, IX_EQ
    } pwr_index_t;
    // Arbitrary identity value
    localparam logic [15:0] ID_CODE = 16'h5a3c;
    // ------------------------------------------------
    // Field positions
    // ------------------------------------------------
    localparam int MID_SEL_HI  = 2;
    localparam int MID_SEL_LO  = 1;
    localparam int BIAS_NORMAL = 1;
    localparam int PW_TSHUT    = 8;
    localparam int PW_TSENSE   = 7;
    localparam int PW_LINE     = 4;
    localparam int PW_SPKPGA   = 2;
    localparam int PW_SPK      = 1;
    localparam int PW_DAC      = 0;
    localparam int CK_OUT      = 5;
    localparam int CK_SLOW     = 2;
    localparam int CK_DSP      = 1;
    localparam int CK_SYS      = 0;
    localparam int CK_DIV_LO   = 12;
    localparam int DIV_W       = 4;
    localparam int FLL_EN      = 0;
    localparam int DRC_EN      = 15;
    localparam int WSEQ_EN     = 15;
    localparam int EQ_EN       = 0;
    // ------------------------------------------------
    // Reset values
    // ------------------------------------------------
    localparam logic [15:0] RST_MID  = 16'h0001;
    localparam logic [15:0] RST_BIAS = 16'h0068;
    localparam logic [15:0] RST_PWR  = 16'h0180;
    localparam logic [15:0] RST_CLK  = 16'h0000;
    localparam logic [15:0] RST_FLL  = 16'h0000;
    localparam logic [15:0] RST_DRC  = 16'h0000;
    localparam logic [15:0] RST_WSEQ = 16'h0000;
    localparam logic [15:0] RST_EQ   = 16'h0000;
    localparam logic [NREG-1:0][15:0] RST_IMAGE = {
        RST_EQ, RST_WSEQ, RST_DRC, RST_FLL,
        RST_CLK, RST_PWR, RST_BIAS, RST_MID
    };
endpackage

/* File: logic/pwr_clkdiv_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pwr_clkdiv_if;
    logic                        enable;
    logic [pwr_pkg::DIV_W-1:0]   ratio;
    logic                        clkOut;
    modport ctl (output enable, output ratio, input clkOut);
    modport div (input enable, input ratio, output clkOut);
endinterface
`default_nettype wire

/* File: logic/pwr_clock_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module pwr_clock_divider (
    // Clock and reset
    input  wire logic     system_clock,
    input  wire logic     rst_n,
    // Control and divided clock
    pwr_clkdiv_if.div     dv
);
    typedef struct packed {
        logic [pwr_pkg::DIV_W-1:0] cnt;
        logic                      clk;
    } pwr_div_t;

    pwr_div_t q;
    pwr_div_t nxt;

    // Half period is ratio+1 system cycles
    always_comb begin
        nxt = q;
        if (!dv.enable) begin
            nxt.cnt = '0;
            nxt.clk = 1'b0;
        end else if (q.cnt >= dv.ratio) begin
            nxt.cnt = '0;
            nxt.clk = ~q.clk;
        end else begin
            nxt.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge system_clock) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= nxt;
        end
    end

    assign dv.clkOut = q.clk;

    div_idle_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        !dv.enable |=> !dv.clkOut)
        else $error("divided clock runs while disabled");
endmodule
`default_nettype wire

/* File: logic/pwr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module pwr_regs (
    // Clock and reset
    input  wire logic        system_clock,
    input  wire logic        rst_n,
    // Control register port
    input  wire logic        wrEn,
    input  wire logic        rdEn,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wrData,
    output logic      [15:0] rdData,
    output logic             rdValid,
    // Thermal event
    input  wire logic        overTemp,
    // Analogue power enables
    output logic      [1:0]  midrailDividerSelect,
    output logic             normalCurrentSourceOn,
    output logic             temperatureSensorEnable,
    output logic             thermalShutdownActive,
    output logic             lineOutputEnable,
    output logic             speakerGainStageEnable,
    output logic             speakerOutputEnable,
    output logic             converterEnable,
    // Clock and function enables
    output logic             slowClockEnable,
    output logic             processingClockEnable,
    output logic             systemClockEnable,
    output logic             lockedLoopEnable,
    output logic             rangeControllerEnable,
    output logic             writeSequencerEnable,
    output logic             parametricFilterEnable,
    // Master clock pin, output side
    output logic             mclkOut,
    output logic             mclkOe
);
    // ------------------------------------------------
    // State
    // ------------------------------------------------
    typedef struct packed {
        logic [pwr_pkg::NREG-1:0][15:0] regs;
        logic [15:0]                    rdData;
        logic                           rdValid;
        logic                           biasOn;
        logic                           trip;
        logic                           lineOn;
        logic                           spkPgaOn;
        logic                           spkOn;
    } pwr_state_t;

    pwr_state_t q;
    pwr_state_t nxt;

    logic [15:0] pwrNxt;
    logic [15:0] midNxt;
    logic [15:0] biasNxt;
    logic        hitWr;
    logic        hitRd;
    logic [2:0]  idxWr;
    logic [2:0]  idxRd;

    // ------------------------------------------------
    // Address decode
    // ------------------------------------------------
    // Returns {hit, index}; 00h is handled apart
    function automatic logic [3:0] regDecode(
        input logic [7:0] a
    );
        logic [3:0] r;
        r = '0;
        case (a)
            pwr_pkg::ADDR_MID:  r = {1'b1, pwr_pkg::IX_MID};
            pwr_pkg::ADDR_BIAS: r = {1'b1, pwr_pkg::IX_BIAS};
            pwr_pkg::ADDR_PWR:  r = {1'b1, pwr_pkg::IX_PWR};
            pwr_pkg::ADDR_CLK:  r = {1'b1, pwr_pkg::IX_CLK};
            pwr_pkg::ADDR_FLL:  r = {1'b1, pwr_pkg::IX_FLL};
            pwr_pkg::ADDR_DRC:  r = {1'b1, pwr_pkg::IX_DRC};
            pwr_pkg::ADDR_WSEQ: r = {1'b1, pwr_pkg::IX_WSEQ};
            pwr_pkg::ADDR_EQ:   r = {1'b1, pwr_pkg::IX_EQ};
            default:            r = '0;
        endcase
        return r;
    endfunction

    assign {hitWr, idxWr} = regDecode(addr);
    assign {hitRd, idxRd} = {hitWr, idxWr};

    // ------------------------------------------------
    // Next state
    // ------------------------------------------------
    always_comb begin
        nxt         = q;
        nxt.rdValid = 1'b0;
        // Write: one register (00h reloads all), so others keep
        // their fields across enable changes
        if (wrEn) begin
            if (addr == pwr_pkg::ADDR_ID) begin
                nxt.regs = pwr_pkg::RST_IMAGE;
            end else if (hitWr) begin
                nxt.regs[idxWr] = wrData;
            end
        end
        // Read returns the value before a same-cycle write
        if (rdEn) begin
            nxt.rdValid = 1'b1;
            if (addr == pwr_pkg::ADDR_ID) begin
                nxt.rdData = pwr_pkg::ID_CODE;
            end else if (hitRd) begin
                nxt.rdData = q.regs[idxRd];
            end else begin
                nxt.rdData = '0;
            end
        end
        pwrNxt  = nxt.regs[pwr_pkg::IX_PWR];
        midNxt  = nxt.regs[pwr_pkg::IX_MID];
        biasNxt = nxt.regs[pwr_pkg::IX_BIAS];
        // Bias generator is useless without the reference
        nxt.biasOn = biasNxt[pwr_pkg::BIAS_NORMAL]
            & |midNxt[pwr_pkg::MID_SEL_HI:pwr_pkg::MID_SEL_LO];
        // Shutdown arm alone does nothing without the sensor
        nxt.trip = pwrNxt[pwr_pkg::PW_TSHUT]
            & pwrNxt[pwr_pkg::PW_TSENSE] & overTemp;
        nxt.lineOn   = pwrNxt[pwr_pkg::PW_LINE] & ~nxt.trip;
        nxt.spkPgaOn = pwrNxt[pwr_pkg::PW_SPKPGA] & ~nxt.trip;
        nxt.spkOn    = pwrNxt[pwr_pkg::PW_SPK] & ~nxt.trip;
    end

    always_ff @(posedge system_clock) begin
        if (!rst_n) begin
            q          <= '0;
            q.regs     <= pwr_pkg::RST_IMAGE;
        end else begin
            q <= nxt;
        end
    end

    // ------------------------------------------------
    // Output clock divider
    // ------------------------------------------------
    pwr_clkdiv_if divBus ();

    assign divBus.enable = q.regs[pwr_pkg::IX_CLK][pwr_pkg::CK_OUT];
    assign divBus.ratio  =
        q.regs[pwr_pkg::IX_CLK][pwr_pkg::CK_DIV_LO +: pwr_pkg::DIV_W];

    pwr_clock_divider uDiv (
        .system_clock (system_clock),
        .rst_n   (rst_n),
        .dv      (divBus)
    );

    // ------------------------------------------------
    // Outputs
    // ------------------------------------------------
    assign rdData  = q.rdData;
    assign rdValid = q.rdValid;

    assign midrailDividerSelect =
        q.regs[pwr_pkg::IX_MID][pwr_pkg::MID_SEL_HI:pwr_pkg::MID_SEL_LO];
    assign normalCurrentSourceOn   = q.biasOn;
    assign temperatureSensorEnable =
        q.regs[pwr_pkg::IX_PWR][pwr_pkg::PW_TSENSE];
    assign thermalShutdownActive   = q.trip;
    assign lineOutputEnable        = q.lineOn;
    assign speakerGainStageEnable  = q.spkPgaOn;
    assign speakerOutputEnable     = q.spkOn;
    assign converterEnable =
        q.regs[pwr_pkg::IX_PWR][pwr_pkg::PW_DAC];

    assign slowClockEnable =
        q.regs[pwr_pkg::IX_CLK][pwr_pkg::CK_SLOW];
    assign processingClockEnable =
        q.regs[pwr_pkg::IX_CLK][pwr_pkg::CK_DSP];
    assign systemClockEnable =
        q.regs[pwr_pkg::IX_CLK][pwr_pkg::CK_SYS];
    assign lockedLoopEnable =
        q.regs[pwr_pkg::IX_FLL][pwr_pkg::FLL_EN];
    assign rangeControllerEnable =
        q.regs[pwr_pkg::IX_DRC][pwr_pkg::DRC_EN];
    assign writeSequencerEnable =
        q.regs[pwr_pkg::IX_WSEQ][pwr_pkg::WSEQ_EN];
    assign parametricFilterEnable =
        q.regs[pwr_pkg::IX_EQ][pwr_pkg::EQ_EN];

    // Pin only driven while the output clock is on
    assign mclkOe  = divBus.enable;
    assign mclkOut = divBus.clkOut;

    // ------------------------------------------------
    // Checks
    // ------------------------------------------------
    sequence wrAt(logic [7:0] a);
        wrEn && addr == a;
    endsequence

    sequence rdAt(logic [7:0] a);
        rdEn && !wrEn && addr == a;
    endsequence

    id_read_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        rdAt(pwr_pkg::ADDR_ID) |=> rdValid && rdData == pwr_pkg::ID_CODE)
        else $error("identity read wrong");

    soft_reset_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        wrAt(pwr_pkg::ADDR_ID) |=> !lineOutputEnable && !converterEnable
            && temperatureSensorEnable && midrailDividerSelect == 2'h0
            && !systemClockEnable && !lockedLoopEnable)
        else $error("soft reset left state");

    midrail_field_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        wrAt(pwr_pkg::ADDR_MID) |=> midrailDividerSelect
            == $past(wrData[pwr_pkg::MID_SEL_HI:pwr_pkg::MID_SEL_LO]))
        else $error("midrail select not taken");

    bias_needs_ref_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        normalCurrentSourceOn |-> midrailDividerSelect != 2'h0)
        else $error("bias on without reference");

    bias_on_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        wrAt(pwr_pkg::ADDR_BIAS) ##0 midrailDividerSelect != 2'h0
            |=> normalCurrentSourceOn == $past(wrData[pwr_pkg::BIAS_NORMAL]))
        else $error("bias enable wrong");

    thermal_trip_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        !wrEn && overTemp && temperatureSensorEnable
            && q.regs[pwr_pkg::IX_PWR][pwr_pkg::PW_TSHUT]
            |=> !lineOutputEnable && !speakerOutputEnable
            && !speakerGainStageEnable)
        else $error("outputs not shut on overtemp");

    no_sensor_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        !wrEn && !temperatureSensorEnable |=> !thermalShutdownActive)
        else $error("shutdown without sensor");

    power_bits_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        wrAt(pwr_pkg::ADDR_PWR) ##0 !overTemp |=>
            converterEnable == $past(wrData[pwr_pkg::PW_DAC])
            && speakerOutputEnable == $past(wrData[pwr_pkg::PW_SPK])
            && speakerGainStageEnable == $past(wrData[pwr_pkg::PW_SPKPGA])
            && lineOutputEnable == $past(wrData[pwr_pkg::PW_LINE])
            && temperatureSensorEnable == $past(wrData[pwr_pkg::PW_TSENSE]))
        else $error("power enables not taken");

    clock_bits_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        wrAt(pwr_pkg::ADDR_CLK) |=>
            systemClockEnable == $past(wrData[pwr_pkg::CK_SYS])
            && processingClockEnable == $past(wrData[pwr_pkg::CK_DSP])
            && slowClockEnable == $past(wrData[pwr_pkg::CK_SLOW])
            && mclkOe == $past(wrData[pwr_pkg::CK_OUT]))
        else $error("clock enables not taken");

    func_bits_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        wrAt(pwr_pkg::ADDR_DRC) |=>
            rangeControllerEnable == $past(wrData[pwr_pkg::DRC_EN]))
        else $error("range controller enable wrong");

    keep_fields_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        wrAt(pwr_pkg::ADDR_PWR) |=>
            $stable(q.regs[pwr_pkg::IX_CLK]) && $stable(midrailDividerSelect))
        else $error("write disturbed another register");

    clkout_quiet_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        !mclkOe [*2] |-> !mclkOut)
        else $error("output clock driven while off");

    // ------------------------------------------------
    // Thermal gate, function enables and read path
    // ------------------------------------------------
    // Armed only when both thermal bits are set and no write moves them
    sequence tripArmed;
        !wrEn && temperatureSensorEnable && q.regs[pwr_pkg::IX_PWR][pwr_pkg::PW_TSHUT];
    endsequence

    trip_level_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        tripArmed ##0 overTemp |=> thermalShutdownActive)
        else $error("shutdown flag not raised on overtemp");

    trip_release_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        !overTemp |=> !thermalShutdownActive)
        else $error("shutdown flag held after event cleared");

    outputs_gated_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        thermalShutdownActive |->
            !lineOutputEnable && !speakerOutputEnable && !speakerGainStageEnable)
        else $error("audio output on during shutdown");

    slow_clock_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        wrAt(pwr_pkg::ADDR_CLK) |=>
            slowClockEnable == $past(wrData[pwr_pkg::CK_SLOW]))
        else $error("slow clock enable not taken");

    ratio_taken_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        wrAt(pwr_pkg::ADDR_CLK) |=>
            divBus.ratio == $past(wrData[pwr_pkg::CK_DIV_LO +: pwr_pkg::DIV_W]))
        else $error("output clock divider not taken");

    loop_enable_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        wrAt(pwr_pkg::ADDR_FLL) |=>
            lockedLoopEnable == $past(wrData[pwr_pkg::FLL_EN]))
        else $error("locked loop enable wrong");

    seq_enable_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        wrAt(pwr_pkg::ADDR_WSEQ) |=>
            writeSequencerEnable == $past(wrData[pwr_pkg::WSEQ_EN]))
        else $error("write sequencer enable wrong");

    filter_enable_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        wrAt(pwr_pkg::ADDR_EQ) |=>
            parametricFilterEnable == $past(wrData[pwr_pkg::EQ_EN]))
        else $error("filter enable wrong");

    soft_image_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        wrAt(pwr_pkg::ADDR_ID) |=> q.regs == pwr_pkg::RST_IMAGE)
        else $error("soft reset image incomplete");

    ref_off_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        wrAt(pwr_pkg::ADDR_MID)
            ##0 wrData[pwr_pkg::MID_SEL_HI:pwr_pkg::MID_SEL_LO] == 2'h0
            |=> !normalCurrentSourceOn)
        else $error("bias left on with reference off");

    // Ties the read path to the enables it reports
    read_state_a: assert property (@(posedge system_clock) disable iff (!rst_n)
        rdAt(pwr_pkg::ADDR_PWR) |=> rdData[pwr_pkg::PW_DAC] == $past(converterEnable)
            && rdData[pwr_pkg::PW_TSENSE] == $past(temperatureSensorEnable))
        else $error("power register read disagrees with enables");
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ---------------------------------------------
    // Design ports
    // ---------------------------------------------
    logic        system_clock;
    logic        rst_n;
    logic        wrEn;
    logic        rdEn;
    logic [7:0]  addr;
    logic [15:0] wrData;
    logic [15:0] rdData;
    logic        rdValid;
    logic        overTemp;
    logic [1:0]  midrailDividerSelect;
    logic        normalCurrentSourceOn;
    logic        temperatureSensorEnable;
    logic        thermalShutdownActive;
    logic        lineOutputEnable;
    logic        speakerGainStageEnable;
    logic        speakerOutputEnable;
    logic        converterEnable;
    logic        slowClockEnable;
    logic        processingClockEnable;
    logic        systemClockEnable;
    logic        lockedLoopEnable;
    logic        rangeControllerEnable;
    logic        writeSequencerEnable;
    logic        parametricFilterEnable;
    logic        mclkOut;
    logic        mclkOe;
    // ---------------------------------------------
    // Bench state
    // ---------------------------------------------
    logic [15:0] shadow  [0:7];
    logic [7:0]  addrTab [0:7];
    logic [31:0] seed;
    logic [15:0] v;
    int          fails;
    int          num_checks;
    wire logic [16:0] gotOuts;
    assign gotOuts = {midrailDividerSelect, normalCurrentSourceOn, temperatureSensorEnable,
        thermalShutdownActive, lineOutputEnable, speakerGainStageEnable, speakerOutputEnable,
        converterEnable, slowClockEnable, processingClockEnable, systemClockEnable,
        lockedLoopEnable, rangeControllerEnable, writeSequencerEnable,
        parametricFilterEnable, mclkOe};
    pwr_regs dut (
        .system_clock(system_clock), .rst_n(rst_n), .wrEn(wrEn), .rdEn(rdEn), .addr(addr),
        .wrData(wrData), .rdData(rdData), .rdValid(rdValid), .overTemp(overTemp),
        .midrailDividerSelect(midrailDividerSelect),
        .normalCurrentSourceOn(normalCurrentSourceOn),
        .temperatureSensorEnable(temperatureSensorEnable),
        .thermalShutdownActive(thermalShutdownActive),
        .lineOutputEnable(lineOutputEnable), .speakerGainStageEnable(speakerGainStageEnable),
        .speakerOutputEnable(speakerOutputEnable), .converterEnable(converterEnable),
        .slowClockEnable(slowClockEnable), .processingClockEnable(processingClockEnable),
        .systemClockEnable(systemClockEnable), .lockedLoopEnable(lockedLoopEnable),
        .rangeControllerEnable(rangeControllerEnable),
        .writeSequencerEnable(writeSequencerEnable),
        .parametricFilterEnable(parametricFilterEnable), .mclkOut(mclkOut), .mclkOe(mclkOe)
    );
    // ---------------------------------------------
    // Expectations
    // ---------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Trip is a level gate on the audio outputs; the converter stays on
    function automatic logic [16:0] expOuts(input logic ot);
        logic [15:0] p;
        logic [15:0] c;
        logic        trip;
        p = shadow[2];
        c = shadow[3];
        trip = p[8] & p[7] & ot;
        expOuts = {shadow[0][2:1], shadow[1][1] & (shadow[0][2:1] != 2'b00), p[7], trip,
            p[4] & !trip, p[2] & !trip, p[1] & !trip, p[0], c[2], c[1], c[0],
            shadow[4][0], shadow[5][15], shadow[6][15], shadow[7][0], c[5]};
    endfunction
    task automatic test_done();
        if (fails == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: expected %h, got %h", $time, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge system_clock);
        #1;
    endtask
    task automatic setDefaults();
        for (int k = 0; k < 8; k++) shadow[k] = pwr_pkg::RST_IMAGE[k];
    endtask
    // ---------------------------------------------
    // Register port cycles
    // ---------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wrEn = 1'b1;
        addr = a;
        wrData = d;
        tick(1);
        wrEn = 1'b0;
        if (a == 8'h00) setDefaults();
        for (int k = 0; k < 8; k++) if (addrTab[k] == a) shadow[k] = d;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        rdEn = 1'b1;
        addr = a;
        tick(1);
        rdEn = 1'b0;
        if (rdValid !== 1'b1) begin
            check(32'h1, rdValid);
            test_done();
        end
        d = rdData;
        tick(1);
    endtask
    task automatic chkAll();
        logic [15:0] r;
        tick(2);
        check(expOuts(overTemp), gotOuts);
        for (int k = 0; k < 8; k++) begin
            rd(addrTab[k], r);
            check(shadow[k], r);
        end
        rd(8'h00, r);
        check(pwr_pkg::ID_CODE, r);
    endtask
    task automatic clkPin(input logic [3:0] d);
        logic last;
        int   n;
        wr(8'h0e, {d, shadow[3][11:6], 1'b1, shadow[3][4:0]});
        tick(2);
        check(32'h1, mclkOe);
        last = mclkOut;
        n = 0;
        while (mclkOut === last && n < 40) begin
            tick(1);
            n++;
        end
        if (n >= 40) begin
            check(32'h0, n);
            test_done();
        end
        last = mclkOut;
        n = 0;
        while (mclkOut === last && n < 40) begin
            tick(1);
            n++;
        end
        check({28'h0, d} + 32'h1, n);
        if (n >= 40) test_done();
    endtask
    // ---------------------------------------------
    // Clock and main sequence
    // ---------------------------------------------
    initial begin
        system_clock = 1'b0;
        forever #2 system_clock = ~system_clock;
    end
    initial begin
        seed = 32'h7700f86e;
        fails = 0;
        num_checks = 0;
        rst_n = 1'b0;
        wrEn = 1'b0;
        rdEn = 1'b0;
        addr = 8'h00;
        wrData = 16'h0000;
        overTemp = 1'b0;
        addrTab = '{8'h04, 8'h05, 8'h0b, 8'h0e, 8'h10, 8'h20, 8'h26, 8'h2a};
        setDefaults();
        tick(5);
        rst_n = 1'b1;
        tick(1);
        check(expOuts(1'b0), gotOuts);
        rd(8'h0b, v);
        check(16'h0180, v);
        rd(8'h01, v);
        check(16'h0000, v);
        wr(8'h07, 16'hffff);
        chkAll();
        wr(8'h05, 16'h006a);
        for (int m = 0; m < 4; m++) begin
            wr(8'h04, {13'h0000, m[1:0], 1'b1});
            chkAll();
        end
        // Sensor on, then off, with the event held high
        overTemp = 1'b1;
        wr(8'h0b, 16'h0197);
        chkAll();
        wr(8'h0b, 16'h0117);
        chkAll();
        wr(8'h0b, 16'h0197);
        overTemp = 1'b0;
        chkAll();
        wr(8'h10, 16'h0001);
        wr(8'h20, 16'h8000);
        wr(8'h26, 16'h8000);
        wr(8'h2a, 16'h0001);
        chkAll();
        clkPin(4'h0);
        clkPin(4'hf);
        clkPin(seed[3:0]);
        repeat (40) begin
            seed = lfsr(seed);
            wr(addrTab[seed[2:0]], seed[31:16]);
            overTemp = seed[5];
            chkAll();
        end
        // Soft reset with arbitrary data restores every register
        wr(8'h00, seed[15:0]);
        chkAll();
        wr(8'h0b, 16'h0017);
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        setDefaults();
        overTemp = 1'b0;
        chkAll();
        test_done();
    end
endmodule
`default_nettype wire
